// file: rtl/fppc_flash_program_protect_ctrl.sv
// fppc_flash_program_protect_ctrl: byte programming, page select, sector guard and
// option load for the on-chip program flash.
// assumes an asynchronous-read flash array and a core that honours cpu_stall.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] control write 00 resets the controller
// [R2] code 5E maps sector guard at FF9
// [R3] software resets, selects page, writes 73
// [R4] unlocked in-page memory write programs byte
// [R5] erased reads FF; programming only clears
// [R6] stall core and hold interrupts while programming
// [R7] control write 00 relocks, ends programming
// [R8] ignore off-page and protected-sector writes
// [R9] page field drives address bits 15:9
// [R10] bit 7 maps info area at FE00-FFFF
// [R11] set sector bit blocks program and erase
// [R12] sector guard writes only set bits
// [R13] write-protect option refuses all programming
// [R14] at most two programs per erase; the controller does not count them and accepts every valid write
// [R15] reload option byte on every reset
// [R16] options drive watchdog, protection, brown-out, oscillator
// [R17] option registers not in register file
// [R18] option byte at 0000, 0001 reserved
// [R19] ignored writes change nothing, no stall
module fppc_flash_program_protect_ctrl #(
  parameter int PROG_CYCLES = fppc_pkg::PROG_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        stop_recover,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output var  logic        cpu_stall,
  output var  logic        irq_hold,
  output var  logic [15:0] flash_addr,
  output var  logic        flash_info_sel,
  output var  logic        flash_read,
  input  wire logic [7:0]  flash_rdata,
  output var  logic        flash_prog,
  output var  logic [7:0]  flash_wdata,
  output var  logic        opt_wdt_irq_mode,
  output var  logic        opt_wdt_en,
  output var  logic        opt_read_protect,
  output var  logic        opt_write_protect,
  output var  logic        opt_vbo_stop_en,
  output var  logic [2:0]  opt_osc_mode
);

  fppc_pkg::fppc_ctl_t ctl;
  fppc_pkg::fppc_seq_t seq;
  fppc_pkg::fppc_seq_t next_seq;
  logic [7:0]  page_sel;
  logic [7:0]  sector_guard;
  logic [7:0]  prog_cnt;
  logic [7:0]  prog_data;
  logic        info_hit;
  logic        in_page;
  logic        guarded;
  logic        prog_ok;

  function automatic logic is_info(input logic [7:0] sel, input logic [15:0] a);
    is_info = sel[fppc_pkg::INFO_BIT] && (a >= fppc_pkg::INFO_BASE);
  endfunction

  // ----------------------------------------
  // control register and sector guard
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl <= fppc_pkg::CTL_LOCKED;
    end else if (reg_wr && reg_addr == fppc_pkg::CTL_ADDR) begin
      if (reg_wdata == fppc_pkg::PROT_SEL_CODE && ctl == fppc_pkg::CTL_LOCKED) begin
        ctl <= fppc_pkg::CTL_PROT; // [R2]
      end else if (reg_wdata == fppc_pkg::UNLOCK_CODE && ctl == fppc_pkg::CTL_LOCKED) begin
        ctl <= fppc_pkg::CTL_UNLOCKED; // [R3]
      end else begin
        // any other code, 00 among them, relocks
        ctl <= fppc_pkg::CTL_LOCKED; // [R1] [R7]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      page_sel     <= fppc_pkg::PAGE_RESET;
      sector_guard <= fppc_pkg::GUARD_RESET;
    end else if (reg_wr && reg_addr == fppc_pkg::PAGE_ADDR) begin
      if (ctl == fppc_pkg::CTL_PROT) begin
        sector_guard <= sector_guard | reg_wdata; // [R12]
      end else begin
        page_sel <= reg_wdata; // [R9] [R10]
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == fppc_pkg::PAGE_ADDR) begin
        reg_rdata <= (ctl == fppc_pkg::CTL_PROT) ? sector_guard : page_sel; // [R2] [R12]
      end else if (reg_addr == fppc_pkg::CTL_ADDR) begin
        // status view; option registers never appear here
        reg_rdata <= {5'h00, cpu_stall, ctl == fppc_pkg::CTL_PROT, ctl == fppc_pkg::CTL_UNLOCKED}; // [R17]
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // write acceptance
  // ----------------------------------------
  always_comb begin
    info_hit = is_info(page_sel, mem_addr); // [R10]
    in_page  = info_hit || (!is_info(page_sel, mem_addr)
               && mem_addr[15:fppc_pkg::PAGE_LSB] == page_sel[6:0]); // [R9]
    guarded  = !info_hit && sector_guard[mem_addr[15:fppc_pkg::SECTOR_LSB]]; // [R11]
    // refused writes simply fall through: no stall, no array activity
    prog_ok  = mem_wr && ctl == fppc_pkg::CTL_UNLOCKED && seq == fppc_pkg::SEQ_IDLE
               && in_page && !guarded && !opt_write_protect; // [R4] [R8] [R13] [R19]
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    next_seq = seq;
    unique case (seq)
      fppc_pkg::SEQ_OPT: begin
        next_seq = fppc_pkg::SEQ_IDLE;
      end
      fppc_pkg::SEQ_IDLE: begin
        if (stop_recover) begin
          next_seq = fppc_pkg::SEQ_OPT; // [R15]
        end else if (prog_ok) begin
          next_seq = fppc_pkg::SEQ_PROG_RD; // [R4]
        end
      end
      fppc_pkg::SEQ_PROG_RD: begin
        next_seq = fppc_pkg::SEQ_PROG_WR;
      end
      fppc_pkg::SEQ_PROG_WR: begin
        if (prog_cnt == 8'(PROG_CYCLES - 1)) begin
          next_seq = fppc_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq <= fppc_pkg::SEQ_OPT; // [R15]
    end else begin
      seq <= next_seq;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prog_cnt <= fppc_pkg::PROG_CNT_INIT;
    end else if (seq == fppc_pkg::SEQ_PROG_WR) begin
      prog_cnt <= prog_cnt + 8'h01;
    end else begin
      prog_cnt <= fppc_pkg::PROG_CNT_INIT;
    end
  end

  // stall covers option load too; the core must not fetch before options settle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_stall <= 1'b1;
      irq_hold  <= 1'b1;
    end else begin
      cpu_stall <= next_seq != fppc_pkg::SEQ_IDLE; // [R6] [R19]
      irq_hold  <= next_seq != fppc_pkg::SEQ_IDLE; // [R6]
    end
  end

  // ----------------------------------------
  // flash array port
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_addr     <= fppc_pkg::OPT_ADDR;
      flash_info_sel <= 1'b0;
      prog_data      <= fppc_pkg::ERASED_BYTE;
    end else if (seq == fppc_pkg::SEQ_IDLE && stop_recover) begin
      flash_addr     <= fppc_pkg::OPT_ADDR; // [R18]
      flash_info_sel <= 1'b0;
    end else if (prog_ok) begin
      flash_addr     <= {info_hit ? mem_addr[15:fppc_pkg::PAGE_LSB] : page_sel[6:0],
                         mem_addr[fppc_pkg::PAGE_LSB-1:0]}; // [R9]
      flash_info_sel <= info_hit; // [R10]
      prog_data      <= mem_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_read <= 1'b1;
    end else begin
      flash_read <= next_seq == fppc_pkg::SEQ_OPT || next_seq == fppc_pkg::SEQ_PROG_RD;
    end
  end

  // read-modify-write keeps already cleared bits cleared
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_prog  <= 1'b0;
      flash_wdata <= fppc_pkg::ERASED_BYTE;
    end else begin
      flash_prog <= next_seq == fppc_pkg::SEQ_PROG_WR; // [R4]
      if (seq == fppc_pkg::SEQ_PROG_RD) begin
        flash_wdata <= flash_rdata & prog_data; // [R5]
      end
    end
  end

  // ----------------------------------------
  // option configuration
  // ----------------------------------------
  // protection bits are active low so an erased byte leaves the part open
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      opt_wdt_irq_mode  <= 1'b0;
      opt_wdt_en        <= 1'b0;
      opt_read_protect  <= 1'b0;
      opt_write_protect <= 1'b0;
      opt_vbo_stop_en   <= 1'b0;
      opt_osc_mode      <= 3'h0;
    end else if (seq == fppc_pkg::SEQ_OPT) begin
      opt_wdt_irq_mode  <= flash_rdata[fppc_pkg::OPT_WDT_IRQ]; // [R15] [R16]
      opt_wdt_en        <= flash_rdata[fppc_pkg::OPT_WDT_EN]; // [R16]
      opt_read_protect  <= !flash_rdata[fppc_pkg::OPT_RDP_N]; // [R16]
      opt_write_protect <= !flash_rdata[fppc_pkg::OPT_WRP_N]; // [R16]
      opt_vbo_stop_en   <= flash_rdata[fppc_pkg::OPT_VBO_STOP]; // [R16]
      opt_osc_mode      <= flash_rdata[fppc_pkg::OPT_OSC_LSB +: 3]; // [R16]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  ctl_reset_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R1]
    reg_wr && reg_addr == fppc_pkg::CTL_ADDR && reg_wdata == fppc_pkg::CTL_RESET_CODE
    |=> ctl == fppc_pkg::CTL_LOCKED) else $error("control reset code did not lock");

  prot_select_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R2]
    reg_rd && reg_addr == fppc_pkg::PAGE_ADDR && ctl == fppc_pkg::CTL_PROT
    |=> reg_rdata == $past(sector_guard)) else $error("sector guard not mapped after select");

  prog_start_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R4]
    prog_ok |=> cpu_stall ##1 flash_prog [*3]) else $error("accepted write did not program");

  clear_only_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R5]
    $rose(flash_prog) |-> (flash_wdata & ~$past(flash_rdata)) == 8'h00)
    else $error("programming tried to set a bit");

  stall_hold_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R6]
    flash_prog |-> cpu_stall && irq_hold) else $error("core not stalled while programming");

  guard_sticky_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R12]
    ($past(sector_guard) & ~sector_guard) == 8'h00) else $error("sector guard bit cleared");

  guard_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R8]
    seq == fppc_pkg::SEQ_IDLE && mem_wr && guarded && !stop_recover
    |=> !cpu_stall && !flash_read) else $error("guarded write was not ignored");

  wrp_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R13]
    opt_write_protect && seq == fppc_pkg::SEQ_IDLE && mem_wr && !stop_recover
    |=> !cpu_stall && !flash_read)
    else $error("write protect option did not block");

  page_addr_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R9]
    prog_ok && !info_hit |=> flash_addr[15:9] == $past(page_sel[6:0]) && !flash_info_sel)
    else $error("page select not on upper address bits");

  opt_reload_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R15]
    seq == fppc_pkg::SEQ_IDLE && stop_recover
    |=> flash_read && flash_addr == fppc_pkg::OPT_ADDR ##1 !cpu_stall)
    else $error("option byte not reloaded on recovery");

  prot_enter_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R2]
    reg_wr && reg_addr == fppc_pkg::CTL_ADDR && reg_wdata == fppc_pkg::PROT_SEL_CODE
    && ctl == fppc_pkg::CTL_LOCKED |=> ctl == fppc_pkg::CTL_PROT) else $error("protect select code not taken");

  relock_block_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R7]
    ctl != fppc_pkg::CTL_UNLOCKED && seq == fppc_pkg::SEQ_IDLE && mem_wr && !stop_recover
    |=> !cpu_stall && !flash_read) else $error("locked controller started a program");

  off_page_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R19]
    seq == fppc_pkg::SEQ_IDLE && mem_wr && !in_page && !stop_recover
    |=> !cpu_stall && !flash_read) else $error("off-page write was not ignored");

  info_target_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // [R10]
    prog_ok && info_hit |=> flash_info_sel && flash_addr[8:0] == $past(mem_addr[8:0]))
    else $error("info area write not steered to info array");

endmodule // fppc_flash_program_protect_ctrl
`default_nettype wire

// file: rtl/fppc_pkg.sv
// fppc_pkg: constants shared by the flash program and protect controller.
// assumes an 8-bit register file with 12-bit addresses and a 16-bit program address.
`default_nettype none
package fppc_pkg;
  // ----------------------------------------
  // register file addresses and codes
  // ----------------------------------------
  localparam logic [11:0] CTL_ADDR       = 12'hff8;
  localparam logic [11:0] PAGE_ADDR      = 12'hff9;
  localparam logic [7:0]  CTL_RESET_CODE = 8'h00;
  localparam logic [7:0]  PROT_SEL_CODE  = 8'h5e;
  localparam logic [7:0]  UNLOCK_CODE    = 8'h73;
  localparam logic [7:0]  PAGE_RESET     = 8'h00;
  localparam logic [7:0]  GUARD_RESET    = 8'h00;
  localparam logic [7:0]  ERASED_BYTE    = 8'hff;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int          INFO_BIT       = 7;
  localparam int          PAGE_LSB       = 9;
  localparam int          SECTOR_LSB     = 13;
  localparam logic [15:0] INFO_BASE      = 16'hfe00;
  localparam logic [15:0] OPT_ADDR       = 16'h0000;
  localparam int          OPT_WDT_IRQ    = 7;
  localparam int          OPT_WDT_EN     = 6;
  localparam int          OPT_VBO_STOP   = 5;
  localparam int          OPT_RDP_N      = 4;
  localparam int          OPT_WRP_N      = 3;
  localparam int          OPT_OSC_LSB    = 0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_MHZ        = 20;
  localparam int          PROG_TIME_NS   = 2000;
  localparam int          PROG_CYCLES    = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0]  PROG_CNT_INIT  = 8'h00;
  // ----------------------------------------
  // states
  // ----------------------------------------
  typedef enum logic [1:0] {CTL_LOCKED, CTL_PROT, CTL_UNLOCKED} fppc_ctl_t;
  typedef enum logic [1:0] {SEQ_OPT, SEQ_IDLE, SEQ_PROG_RD, SEQ_PROG_WR} fppc_seq_t;
endpackage
`default_nettype wire

// file: tb/fppc_flash_model.sv
// fppc_flash_model: behavioural program flash array beside the controller.
// assumes asynchronous reads and one byte written per cycle of flash_prog.
`timescale 1ns/100ps
`default_nettype none
module fppc_flash_model #(
  parameter logic [7:0] OPT_BYTE = 8'h00
) (
  input  wire logic        sys_clk,
  input  wire logic [15:0] flash_addr,
  input  wire logic        flash_info_sel,
  input  wire logic        flash_read,
  output var  logic [7:0]  flash_rdata,
  input  wire logic        flash_prog,
  input  wire logic [7:0]  flash_wdata
);
  logic [7:0] main_mem [0:65535];
  logic [7:0] info_mem [0:511];
  logic [7:0] cur_byte;
  initial begin
    for (int i = 0; i < 65536; i++) main_mem[i] = 8'hff;
    for (int i = 0; i < 512; i++) info_mem[i] = 8'hff;
    main_mem[0] = OPT_BYTE;
  end
  assign cur_byte = flash_info_sel ? info_mem[flash_addr[8:0]] : main_mem[flash_addr];
  // outside a read the lines show the inverse, so a stale sample never passes
  assign flash_rdata = flash_read ? cur_byte : ~cur_byte;
  // cells can only be cleared; a set bit in the write data changes nothing
  always @(posedge sys_clk) begin
    if (flash_prog && flash_info_sel) info_mem[flash_addr[8:0]] <= info_mem[flash_addr[8:0]] & flash_wdata;
    else if (flash_prog) main_mem[flash_addr] <= main_mem[flash_addr] & flash_wdata;
  end
endmodule // fppc_flash_model
`default_nettype wire

// file: tb/tb_top.sv
// tb_top: self-checking bench for the flash program and protect controller.
// assumes the behavioural array model; inputs change on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int          PROG = 3;
  localparam logic [7:0]  OPT0 = 8'hcd;
  localparam logic [11:0] CTL  = 12'hff8;
  localparam logic [11:0] PAGE = 12'hff9;
  logic        sys_clk, arst_n, stop_recover, reg_wr, reg_rd, mem_wr;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, mem_wdata, flash_rdata, flash_wdata, rd, d;
  logic [15:0] mem_addr, flash_addr, a;
  logic        cpu_stall, irq_hold, flash_info_sel, flash_read, flash_prog;
  logic        opt_wdt_irq_mode, opt_wdt_en, opt_read_protect, opt_write_protect, opt_vbo_stop_en;
  logic [2:0]  opt_osc_mode;
  logic [6:0]  pg;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          n;
  fppc_flash_program_protect_ctrl #(.PROG_CYCLES(PROG)) dut (.sys_clk, .arst_n, .stop_recover, .reg_wr,
    .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .mem_wr, .mem_addr, .mem_wdata, .cpu_stall, .irq_hold,
    .flash_addr, .flash_info_sel, .flash_read, .flash_rdata, .flash_prog, .flash_wdata, .opt_wdt_irq_mode,
    .opt_wdt_en, .opt_read_protect, .opt_write_protect, .opt_vbo_stop_en, .opt_osc_mode);
  fppc_flash_model #(.OPT_BYTE(OPT0)) u_flash (.sys_clk, .flash_addr, .flash_info_sel, .flash_read,
    .flash_rdata, .flash_prog, .flash_wdata);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] opt_exp(input logic [7:0] b);
    return {b[7], b[6], ~b[4], ~b[3], b[5], b[2:0]};
  endfunction
  function automatic logic [7:0] opt_seen();
    return {opt_wdt_irq_mode, opt_wdt_en, opt_read_protect, opt_write_protect, opt_vbo_stop_en, opt_osc_mode};
  endfunction
  task automatic wreg(input logic [11:0] ad, input logic [7:0] dt);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = ad;
    reg_wdata = dt;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rreg(input logic [11:0] ad);
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = ad;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask
  // one memory write, then count the stall cycles it causes
  task automatic memw(input logic [15:0] ad, input logic [7:0] dt);
    @(negedge sys_clk);
    mem_wr = 1'b1;
    mem_addr = ad;
    mem_wdata = dt;
    @(negedge sys_clk);
    mem_wr = 1'b0;
    n = 0;
    while (cpu_stall === 1'b1 && n < 100) begin
      chk(irq_hold, 1, "irq_hold");
      n++;
      @(negedge sys_clk);
    end
    if (n >= 100) begin
      n_errors++;
      end_sim();
    end
  endtask
  task automatic unlock(input logic [7:0] ps);
    wreg(CTL, 8'h00);
    wreg(PAGE, ps);
    wreg(CTL, 8'h73);
  endtask
  task automatic prog_try(input logic [15:0] ad, input logic [7:0] dt, input logic ok);
    logic [7:0] old;
    old = u_flash.main_mem[ad];
    memw(ad, dt);
    chk(16'(n), ok ? 16'(PROG + 1) : 16'h0000, "stall cycles");
    chk(u_flash.main_mem[ad], ok ? old & dt : old, "array byte");
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    {arst_n, stop_recover, reg_wr, reg_rd, mem_wr} = 5'b0_0000;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    mem_addr = 16'h0000;
    mem_wdata = 8'h00;
    void'($urandom(32'h12fb_97c4));
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    chk(cpu_stall, 0, "stall after load");
    chk(opt_seen(), opt_exp(OPT0), "options");
    rreg(PAGE);
    chk(rd, 8'h00, "page reset");
    rreg(12'h100);
    chk(rd, 8'h00, "unmapped read");
    for (int i = 0; i < 6; i++) begin
      pg = 7'($urandom_range(1, 127));
      a = {pg, 9'($urandom)};
      d = 8'($urandom);
      unlock({1'b0, pg});
      rreg(CTL);
      chk(rd[0], 1, "unlocked flag");
      rreg(PAGE);
      chk(rd, {1'b0, pg}, "page select");
      prog_try(a, d, 1'b1);
      prog_try(a ^ 16'h0200, d, 1'b0);
    end
    wreg(CTL, 8'h00);
    prog_try(a, 8'h00, 1'b0);
    unlock(8'h11);
    prog_try(16'h2200, 8'hf0, 1'b1);
    prog_try(16'h2200, 8'h3c, 1'b1);
    unlock(8'h81);
    d = u_flash.info_mem[16];
    memw(16'hfe10, 8'h5a);
    chk(u_flash.info_mem[16], d & 8'h5a, "info byte");
    wreg(CTL, 8'h00);
    wreg(CTL, 8'h5e);
    rreg(CTL);
    chk(rd[1], 1, "guard mapped");
    rreg(PAGE);
    chk(rd, 8'h00, "guard reset");
    wreg(PAGE, 8'h05);
    wreg(PAGE, 8'h00);
    rreg(PAGE);
    chk(rd, 8'h05, "guard set only");
    wreg(CTL, 8'h00);
    rreg(PAGE);
    chk(rd, 8'h81, "page kept");
    unlock(8'h20);
    prog_try(16'h4004, 8'h00, 1'b0);
    unlock(8'h30);
    prog_try(16'h6004, 8'h0f, 1'b1);
    wreg(CTL, 8'h5e);
    rreg(CTL);
    chk(rd, 8'h00, "select while unlocked relocks");
    u_flash.main_mem[0] = 8'hc5;
    @(negedge sys_clk);
    stop_recover = 1'b1;
    @(negedge sys_clk);
    stop_recover = 1'b0;
    @(negedge sys_clk);
    chk(opt_seen(), opt_exp(8'hc5), "options reload");
    unlock(8'h30);
    prog_try(16'h6006, 8'h00, 1'b0);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
